// [seee_regs.svh]
`ifndef SEEE_REGS_SVH
`define SEEE_REGS_SVH

// select word: fixed prefix in the upper nibble, select bits, direction bit
`define SEEE_DEV_PREFIX     4'hA
`define SEEE_PREFIX_MSB     7
`define SEEE_PREFIX_LSB     4
`define SEEE_CS_MSB         3
`define SEEE_CS_LSB         1
`define SEEE_DIR_BIT        0
`define SEEE_ADDR_MSB       6

// byte framing
`define SEEE_BITS_PER_BYTE  4'h8
`define SEEE_BIT_CNT_RST    4'h0

// memory organisation
`define SEEE_ADDR_W         7
`define SEEE_DATA_W         8
`define SEEE_WORDS          128
`define SEEE_ADDR_LAST      7'h7F
`define SEEE_ADDR_RST       7'h00
`define SEEE_DATA_RST       8'h00
`define SEEE_ERASED         8'hFF

// request word carried by the fifo: {write, address, data}
`define SEEE_REQ_W          16
`define SEEE_REQ_WR_BIT     15
`define SEEE_REQ_ADDR_MSB   14
`define SEEE_REQ_ADDR_LSB   8
`define SEEE_REQ_DATA_MSB   7
`define SEEE_FIFO_DEPTH     4

// programming time
`define SEEE_CLK_MHZ        25
`define SEEE_T_PROG_US      10000
`define SEEE_PROG_CYCLES    (`SEEE_T_PROG_US * `SEEE_CLK_MHZ)

`endif

// [seee_pkg.sv]
package seee_pkg;

    typedef enum logic [2:0] {
        SEEE_ST_IDLE,
        SEEE_ST_SEL,
        SEEE_ST_ADDR,
        SEEE_ST_DATA,
        SEEE_ST_TX,
        SEEE_ST_WAIT
    } seee_state_t;

    typedef enum logic [1:0] {
        SEEE_PG_IDLE,
        SEEE_PG_ERASE,
        SEEE_PG_WRITE
    } seee_prog_t;

endpackage

// [seee_mem_if.sv]
`timescale 1ns/1ns
interface seee_mem_if;
    logic       req_valid;
    logic       req_ready;
    logic       req_wr;
    logic [6:0] req_addr;
    logic [7:0] req_data;
    logic       rd_valid;
    logic [7:0] rd_data;
    logic       abort;
    logic       busy;

    modport ctl (
        output req_valid,
        output req_wr,
        output req_addr,
        output req_data,
        output abort,
        input  req_ready,
        input  rd_valid,
        input  rd_data,
        input  busy
    );

    modport mem (
        input  req_valid,
        input  req_wr,
        input  req_addr,
        input  req_data,
        input  abort,
        output req_ready,
        output rd_valid,
        output rd_data,
        output busy
    );
endinterface

// [seee_fifo.sv]
`timescale 1ns/1ns
module seee_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    input  wire logic             clk_sys_i,
    input  wire logic             rst_b_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] store [DEPTH];
    logic [PW:0]      wr_ptr;
    logic [PW:0]      rd_ptr;

    wire empty = (wr_ptr == rd_ptr);
    wire full  = (wr_ptr[PW] != rd_ptr[PW]) && (wr_ptr[PW-1:0] == rd_ptr[PW-1:0]);
    wire push  = in_valid_i && !full;
    wire pop   = out_valid_o && out_ready_i;

    assign in_ready_o  = !full;
    assign out_valid_o = !empty;
    assign out_data_o  = store[rd_ptr[PW-1:0]];

    always_ff @(posedge clk_sys_i) begin
        if (push) begin
            store[wr_ptr[PW-1:0]] <= in_data_i;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end
endmodule

// [seee_prog_mem.sv]
`timescale 1ns/1ns
`include "seee_regs.svh"
module seee_prog_mem
    import seee_pkg::*;
#(
    parameter int unsigned PROG_CYCLES = `SEEE_PROG_CYCLES
) (
    input  wire logic clk_sys_i,
    input  wire logic rst_b_i,
    seee_mem_if.mem   bus
);
    // erase and write each take half of the programming time
    localparam logic [31:0] PHASE_LAST = 32'((PROG_CYCLES / 2) - 1);

    logic [`SEEE_DATA_W-1:0] cells [`SEEE_WORDS];
    seee_prog_t              pstate;
    logic [31:0]             cnt;
    logic [`SEEE_ADDR_W-1:0] paddr;
    logic [`SEEE_DATA_W-1:0] pdata;

    wire phase_done = (pstate != SEEE_PG_IDLE) && !bus.abort && (cnt == PHASE_LAST);
    wire [`SEEE_DATA_W-1:0] next_cell = (pstate == SEEE_PG_ERASE) ?
                                        `SEEE_ERASED : (cells[paddr] & pdata);
    wire take      = bus.req_valid && (pstate == SEEE_PG_IDLE);
    // an already erased word skips erase, an all-ones word skips write;
    // a never written cell compares unknown and must still be erased
    wire skip_erase = (cells[bus.req_addr] == `SEEE_ERASED);
    wire need_write = (bus.req_data != `SEEE_ERASED);

    assign bus.req_ready = (pstate == SEEE_PG_IDLE);
    assign bus.busy      = (pstate != SEEE_PG_IDLE);

    always_ff @(posedge clk_sys_i) begin
        if (phase_done) begin
            cells[paddr] <= next_cell;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pstate       <= SEEE_PG_IDLE;
            cnt          <= 32'h0;
            paddr        <= `SEEE_ADDR_RST;
            pdata        <= `SEEE_DATA_RST;
            bus.rd_valid <= 1'b0;
            bus.rd_data  <= `SEEE_DATA_RST;
        end else begin
            bus.rd_valid <= 1'b0;
            unique case (pstate)
                SEEE_PG_IDLE: begin
                    cnt <= 32'h0;
                    if (take && bus.req_wr) begin
                        paddr <= bus.req_addr;
                        pdata <= bus.req_data;
                        if (skip_erase) begin
                            if (need_write) begin
                                pstate <= SEEE_PG_WRITE;
                            end
                        end else begin
                            pstate <= SEEE_PG_ERASE;
                        end
                    end else if (take) begin
                        bus.rd_data  <= cells[bus.req_addr];
                        bus.rd_valid <= 1'b1;
                    end
                end
                SEEE_PG_ERASE: begin
                    if (bus.abort) begin
                        pstate <= SEEE_PG_IDLE;
                    end else if (phase_done) begin
                        cnt    <= 32'h0;
                        pstate <= (pdata == `SEEE_ERASED) ? SEEE_PG_IDLE : SEEE_PG_WRITE;
                    end else begin
                        cnt <= cnt + 32'h1;
                    end
                end
                SEEE_PG_WRITE: begin
                    if (bus.abort || phase_done) begin
                        pstate <= SEEE_PG_IDLE;
                    end else begin
                        cnt <= cnt + 32'h1;
                    end
                end
                default: begin
                    pstate <= SEEE_PG_IDLE;
                end
            endcase
        end
    end
endmodule

// [seee_i2c_slave.sv]
// What this block does
// - write-select acked only on matching select bits
// - matching read-select acked, then transmit data
// - address byte loads the address register, acked
// - data byte captured msb first, acked low
// - read bytes shifted msb first, released ninth
// - ack low on ninth clock; none on mismatch
// - stop after data byte starts erase (unless already erased) then write (unless data is all ones)
// - write-select aborts programming; read-select ignored then
// - master ack increments address, no wrap; stop idles
`timescale 1ns/1ns
`include "seee_regs.svh"
module seee_i2c_slave
    import seee_pkg::*;
#(
    parameter int unsigned PROG_CYCLES = `SEEE_PROG_CYCLES
) (
    input  wire logic clk_sys_i,
    input  wire logic rst_b_i,
    input  wire logic scl_i,
    input  wire logic sda_i,
    output logic      sda_o,
    output logic      sda_oe_o,
    input  wire logic select_bit_low_i,
    input  wire logic select_bit_mid_i,
    input  wire logic select_bit_high_i,
    output logic      prog_busy_o
);
    seee_mem_if mem_bus ();

    seee_state_t             state;
    logic [3:0]              bit_cnt;
    logic                    in_ack;
    logic [7:0]              shreg;
    logic [7:0]              tx;
    logic                    tx_drive;
    logic                    ack_drive;
    logic [`SEEE_ADDR_W-1:0] addr;
    logic [`SEEE_DATA_W-1:0] wdata;
    logic                    wr_pending;
    logic                    push_pend;
    logic                    push_wr;
    logic                    abort_q;
    logic                    scl_q;
    logic                    sda_q;
    logic                    sda_oe;
    logic                    busy_q;

    // bus events, from the previous sample of both lines
    wire scl_rise  = scl_i && !scl_q;
    wire scl_fall  = !scl_i && scl_q;
    wire start_ev  = scl_i && scl_q && sda_q && !sda_i;
    wire stop_ev   = scl_i && scl_q && !sda_q && sda_i;
    wire byte_done = scl_fall && !in_ack && (bit_cnt == `SEEE_BITS_PER_BYTE);
    wire ack_end   = scl_fall && in_ack;
    wire receiving = (state == SEEE_ST_SEL) || (state == SEEE_ST_ADDR) ||
                     (state == SEEE_ST_DATA);

    // select word decode
    wire [2:0] strap      = {select_bit_high_i, select_bit_mid_i, select_bit_low_i};
    wire       prefix_ok  = (shreg[`SEEE_PREFIX_MSB:`SEEE_PREFIX_LSB] == `SEEE_DEV_PREFIX);
    wire       cs_ok      = (shreg[`SEEE_CS_MSB:`SEEE_CS_LSB] == strap);
    wire       sel_match  = prefix_ok && cs_ok;
    wire       sel_read   = shreg[`SEEE_DIR_BIT];
    wire       sel_wr_ok  = sel_match && !sel_read;
    wire       sel_rd_ok  = sel_match && sel_read && !busy_q;
    wire       accept     = (state != SEEE_ST_SEL) || sel_wr_ok || sel_rd_ok;
    wire       next_oe    = ack_drive || (tx_drive && !tx[7]);

    wire                    fifo_ready;
    wire [`SEEE_REQ_W-1:0]  fifo_out;
    wire [`SEEE_REQ_W-1:0]  fifo_in = {push_wr, addr, push_wr ? wdata : `SEEE_DATA_RST};
    wire [`SEEE_ADDR_W-1:0] next_addr = (addr == `SEEE_ADDR_LAST) ? addr : addr + 1'b1;

    assign sda_o       = 1'b0;
    assign sda_oe_o    = sda_oe;
    assign prog_busy_o = busy_q;
    assign mem_bus.abort    = abort_q;
    assign mem_bus.req_wr   = fifo_out[`SEEE_REQ_WR_BIT];
    assign mem_bus.req_addr = fifo_out[`SEEE_REQ_ADDR_MSB:`SEEE_REQ_ADDR_LSB];
    assign mem_bus.req_data = fifo_out[`SEEE_REQ_DATA_MSB:0];

    // requests queue ahead of the memory; a push is held until the fifo has room
    seee_fifo #(
        .WIDTH (`SEEE_REQ_W),
        .DEPTH (`SEEE_FIFO_DEPTH)
    ) u_fifo (
        .clk_sys_i   (clk_sys_i),
        .rst_b_i     (rst_b_i),
        .in_valid_i  (push_pend),
        .in_ready_o  (fifo_ready),
        .in_data_i   (fifo_in),
        .out_valid_o (mem_bus.req_valid),
        .out_ready_i (mem_bus.req_ready),
        .out_data_o  (fifo_out)
    );

    seee_prog_mem #(
        .PROG_CYCLES (PROG_CYCLES)
    ) u_mem (
        .clk_sys_i (clk_sys_i),
        .rst_b_i   (rst_b_i),
        .bus       (mem_bus)
    );

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            scl_q  <= 1'b1;
            sda_q  <= 1'b1;
            sda_oe <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            scl_q  <= scl_i;
            sda_q  <= sda_i;
            sda_oe <= next_oe;
            busy_q <= mem_bus.busy;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state      <= SEEE_ST_IDLE;
            bit_cnt    <= `SEEE_BIT_CNT_RST;
            in_ack     <= 1'b0;
            shreg      <= `SEEE_DATA_RST;
            tx         <= `SEEE_ERASED;
            tx_drive   <= 1'b0;
            ack_drive  <= 1'b0;
            addr       <= `SEEE_ADDR_RST;
            wdata      <= `SEEE_DATA_RST;
            wr_pending <= 1'b0;
            push_pend  <= 1'b0;
            push_wr    <= 1'b0;
            abort_q    <= 1'b0;
        end else begin
            abort_q <= 1'b0;
            if (push_pend && fifo_ready) begin
                push_pend <= 1'b0;
            end
            if (mem_bus.rd_valid) begin
                tx <= mem_bus.rd_data;
            end
            if (start_ev) begin
                // a repeated start drops a write that was not closed by stop
                state      <= SEEE_ST_SEL;
                bit_cnt    <= `SEEE_BIT_CNT_RST;
                in_ack     <= 1'b0;
                ack_drive  <= 1'b0;
                tx_drive   <= 1'b0;
                wr_pending <= 1'b0;
            end else if (stop_ev) begin
                state     <= SEEE_ST_IDLE;
                bit_cnt   <= `SEEE_BIT_CNT_RST;
                in_ack    <= 1'b0;
                ack_drive <= 1'b0;
                tx_drive  <= 1'b0;
                if (wr_pending) begin
                    push_pend  <= 1'b1;
                    push_wr    <= 1'b1;
                    wr_pending <= 1'b0;
                end
            end else if (receiving) begin
                if (scl_rise && !in_ack) begin
                    shreg   <= {shreg[6:0], sda_q};
                    bit_cnt <= bit_cnt + 1'b1;
                end
                if (byte_done && !accept) begin
                    state <= SEEE_ST_WAIT;
                end else if (byte_done) begin
                    in_ack    <= 1'b1;
                    ack_drive <= 1'b1;
                    unique case (state)
                        SEEE_ST_SEL: begin
                            if (sel_read) begin
                                push_pend <= 1'b1;
                                push_wr   <= 1'b0;
                            end else begin
                                abort_q <= busy_q;
                            end
                        end
                        SEEE_ST_ADDR: begin
                            addr <= shreg[`SEEE_ADDR_MSB:0];
                        end
                        SEEE_ST_DATA: begin
                            wdata      <= shreg;
                            wr_pending <= 1'b1;
                        end
                        default: begin
                            state <= SEEE_ST_WAIT;
                        end
                    endcase
                end
                if (ack_end) begin
                    in_ack    <= 1'b0;
                    ack_drive <= 1'b0;
                    bit_cnt   <= `SEEE_BIT_CNT_RST;
                    unique case (state)
                        SEEE_ST_SEL: begin
                            state    <= sel_read ? SEEE_ST_TX : SEEE_ST_ADDR;
                            tx_drive <= sel_read;
                        end
                        SEEE_ST_ADDR: begin
                            state <= SEEE_ST_DATA;
                        end
                        default: begin
                            state <= SEEE_ST_WAIT;
                        end
                    endcase
                end
            end else if (state == SEEE_ST_TX) begin
                if (scl_rise && in_ack && !sda_q) begin
                    addr      <= next_addr;
                    push_pend <= 1'b1;
                    push_wr   <= 1'b0;
                end else if (scl_rise && in_ack) begin
                    state  <= SEEE_ST_WAIT;
                    in_ack <= 1'b0;
                end else if (scl_rise) begin
                    bit_cnt <= bit_cnt + 1'b1;
                end
                if (scl_fall && !in_ack && (bit_cnt == `SEEE_BITS_PER_BYTE)) begin
                    tx_drive <= 1'b0;
                    in_ack   <= 1'b1;
                end else if (scl_fall && !in_ack && (bit_cnt != `SEEE_BIT_CNT_RST)) begin
                    tx <= {tx[6:0], 1'b1};
                end else if (ack_end) begin
                    in_ack   <= 1'b0;
                    bit_cnt  <= `SEEE_BIT_CNT_RST;
                    tx_drive <= 1'b1;
                end
            end
        end
    end
endmodule

// [seee_i2c_slave_monitor.sv]
`timescale 1ns/1ns
module seee_i2c_slave_monitor #(
    parameter int unsigned PROG_CYCLES = 20
) (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_o,
    input wire logic select_bit_low_i,
    input wire logic select_bit_mid_i,
    input wire logic select_bit_high_i,
    input wire logic prog_busy_o
);
    int unsigned busy_cnt;

    // a busy flag that never drops shows up as an overrun of this count
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            busy_cnt <= 0;
        end else if (prog_busy_o) begin
            busy_cnt <= busy_cnt + 1;
        end else begin
            busy_cnt <= 0;
        end
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);

    property p_od;
        sda_oe_o |-> sda_o == 1'b0;
    endproperty
    a_od: assert property (p_od) else $error("data line driven high");
    property p_rst;
        disable iff (1'b0) !rst_b_i |=> !sda_oe_o && !prog_busy_o;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs active after reset");
    property p_rise;
        $rose(sda_oe_o) |-> !scl_i && !$past(scl_i);
    endproperty
    a_rise: assert property (p_rise) else $error("drive began outside clock low");
    property p_fall;
        $fell(sda_oe_o) |-> !scl_i && !$past(scl_i);
    endproperty
    a_fall: assert property (p_fall) else $error("acknowledge cut short");
    property p_stable;
        scl_i && $past(scl_i) |-> $stable(sda_oe_o);
    endproperty
    a_stable: assert property (p_stable) else $error("drive changed with clock high");
    property p_stop;
        scl_i && $past(scl_i) && $rose(sda_i) |=> !sda_oe_o [*4];
    endproperty
    a_stop: assert property (p_stop) else $error("line driven after stop");
    property p_busy_start;
        $rose(prog_busy_o) |-> scl_i && sda_i;
    endproperty
    a_busy_start: assert property (p_busy_start) else $error("busy rose on active bus");
    property p_busy_len;
        busy_cnt <= PROG_CYCLES;
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("programming overran");
endmodule

// [seee_i2c_master_model.sv]
`timescale 1ns/1ns
module seee_i2c_master_model (
    input  wire logic clk_sys_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_pull_o
);
    localparam int HALF = 10;

    initial begin
        scl_o      = 1'b1;
        sda_pull_o = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask

    // data moves two cycles after the clock falls so no edge is seen as a start or stop
    task automatic start();
        tick(2);
        sda_pull_o = 1'b0;
        tick(HALF);
        scl_o = 1'b1;
        tick(HALF);
        sda_pull_o = 1'b1;
        tick(HALF);
        scl_o = 1'b0;
    endtask

    task automatic stop();
        tick(2);
        sda_pull_o = 1'b1;
        tick(HALF);
        scl_o = 1'b1;
        tick(HALF);
        sda_pull_o = 1'b0;
        tick(HALF);
    endtask

    task automatic clock(input logic b, output logic s);
        tick(2);
        sda_pull_o = !b;
        tick(HALF);
        scl_o = 1'b1;
        tick(HALF / 2);
        s = sda_i;
        tick(HALF / 2);
        scl_o = 1'b0;
    endtask

    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clock(d[i], s);
        end
        clock(1'b1, s);
        ack = !s;
    endtask

    task automatic rbyte(input logic more, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clock(1'b1, s);
            d[i] = s;
        end
        clock(!more, s);
    endtask
endmodule

// [test_seee_i2c_slave.sv]
`timescale 1ns/1ns
module test_seee_i2c_slave;
    localparam int unsigned PROG = 2000;
    logic       clk_sys_i;
    logic       rst_b_i;
    logic [2:0] sel;
    logic       scl;
    logic       pull;
    logic       sda_o;
    logic       sda_oe;
    logic       busy;
    wire        sda = !(pull || (sda_oe && !sda_o));
    int         n_errors;
    int         samples_checked;
    int         cycles;

    seee_i2c_slave #(.PROG_CYCLES(PROG)) uut (
        .clk_sys_i        (clk_sys_i),
        .rst_b_i          (rst_b_i),
        .scl_i            (scl),
        .sda_i            (sda),
        .sda_o            (sda_o),
        .sda_oe_o         (sda_oe),
        .select_bit_low_i (sel[0]),
        .select_bit_mid_i (sel[1]),
        .select_bit_high_i(sel[2]),
        .prog_busy_o      (busy)
    );

    seee_i2c_master_model m (
        .clk_sys_i (clk_sys_i),
        .sda_i     (sda),
        .scl_o     (scl),
        .sda_pull_o(pull)
    );

    initial begin
        clk_sys_i = 1'b0;
        forever #20 clk_sys_i = !clk_sys_i;
    end

    task automatic end_sim();
        if (n_errors == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles >= 60000) begin
            n_errors++;
            end_sim();
        end
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            n_errors++;
        end
    endtask

    task automatic wait_busy(input logic lvl);
        for (int i = 0; i < 3000 && busy !== lvl; i++) begin
            m.tick(1);
        end
        check(busy, lvl);
    endtask

    function automatic logic [7:0] sel_word(input logic [2:0] cs, input logic rd);
        return {4'hA, cs, rd};
    endfunction

    task automatic write_word(input logic [6:0] a, input logic [7:0] d);
        logic [2:0] ack;
        m.start();
        m.wbyte(sel_word(sel, 1'b0), ack[2]);
        m.wbyte({1'b0, a}, ack[1]);
        m.wbyte(d, ack[0]);
        m.stop();
        check(ack, 3'b111);
    endtask

    // poll while programming runs, then wait for the cell to settle
    task automatic t_write_poll();
        logic ack;
        write_word(7'h05, 8'h3C);
        wait_busy(1'b1);
        m.start();
        m.wbyte(sel_word(sel, 1'b1), ack);
        m.stop();
        check(ack, 1'b0);
        wait_busy(1'b0);
    endtask

    task automatic read_from(input logic [6:0] a);
        logic ack;
        m.start();
        m.wbyte(sel_word(sel, 1'b0), ack);
        m.wbyte({1'b0, a}, ack);
        m.start();
        m.wbyte(sel_word(sel, 1'b1), ack);
        check(ack, 1'b1);
    endtask

    task automatic t_read();
        logic [7:0] d;
        read_from(7'h05);
        m.rbyte(1'b0, d);
        m.stop();
        check(d, 8'h3C);
        check(sda_oe, 1'b0);
    endtask

    task automatic t_mismatch();
        logic       ack;
        logic [7:0] w [3];
        w = '{sel_word(~sel, 1'b0), sel_word(sel ^ 3'h1, 1'b1), {4'h5, sel, 1'b0}};
        for (int i = 0; i < 3; i++) begin
            m.start();
            m.wbyte(w[i], ack);
            m.stop();
            check(ack, 1'b0);
        end
        // a different strap must follow the select bits
        sel = ~sel;
        m.start();
        m.wbyte(sel_word(sel, 1'b0), ack);
        m.stop();
        check(ack, 1'b1);
        sel = ~sel;
    endtask

    // last location must repeat instead of wrapping to zero
    task automatic t_seq();
        logic [7:0] d;
        write_word(7'h7F, 8'h81);
        wait_busy(1'b1);
        wait_busy(1'b0);
        write_word(7'h7E, 8'h7E);
        wait_busy(1'b1);
        wait_busy(1'b0);
        read_from(7'h7E);
        m.rbyte(1'b1, d);
        check(d, 8'h7E);
        m.rbyte(1'b1, d);
        check(d, 8'h81);
        m.rbyte(1'b0, d);
        m.stop();
        check(d, 8'h81);
    endtask

    task automatic t_abort();
        logic ack;
        write_word(7'h05, 8'h00);
        wait_busy(1'b1);
        m.start();
        m.wbyte(sel_word(sel, 1'b0), ack);
        check({ack, busy}, 2'b10);
        m.stop();
        m.tick(8);
        check(busy, 1'b0);
    endtask

    initial begin
        n_errors        = 0;
        samples_checked = 0;
        cycles          = 0;
        sel             = 3'h5;
        rst_b_i         = 1'b0;
        repeat (4) @(negedge clk_sys_i);
        rst_b_i = 1'b1;
        m.tick(2);
        t_write_poll();
        t_read();
        t_mismatch();
        t_seq();
        t_abort();
        end_sim();
    end
endmodule

bind seee_i2c_slave seee_i2c_slave_monitor #(.PROG_CYCLES(PROG_CYCLES)) u_mon (
    .clk_sys_i        (clk_sys_i),
    .rst_b_i          (rst_b_i),
    .scl_i            (scl_i),
    .sda_i            (sda_i),
    .sda_o            (sda_o),
    .sda_oe_o         (sda_oe_o),
    .select_bit_low_i (select_bit_low_i),
    .select_bit_mid_i (select_bit_mid_i),
    .select_bit_high_i(select_bit_high_i),
    .prog_busy_o      (prog_busy_o)
);
